/* dls_sequencer.sv */
// Dual-loop supply sequencer top: groups, commands, shutdown lines, watchdog.
// Assumes configuration is held stable by the owner of the settings.
//
// How it works
// - Each channel joins group A or B.
// - Start input 0 drives A, 1 drives B.
// - Page-all commands switch group sets on/off.
// - On/off source: pins, commands, or both.
// - Power-up, pins, command, logic start.
// - Enable after on-delay, polarity per channel.
// - Time-based or event-based start per channel.
// - Power-good late beyond limit flags fault.
// - Event wait bounded; zero limit disables.
// - Sense input n supervises enable n.
// - No enable while enabled faults present.
// - Off by off-delays or all at once.
// - Inactive start, off command, shutdown line.
// - Logic and signature never turn off.
// - Faults drive shutdown lines; listeners shut down.
// - Lines 1, 2 borrow margin 7, enable 10.
// - Channel emits signature on power-good.
// - Channels may wait for matching signature.
// - Watchdog refresh 5 ms, reset at 210 ms.
// - Watchdog reset sets status flags, alert.
// - Bad memory check: stay off, assert line 0.
// - Single-page command acts on one channel.
// - Immediate off ignores off-delay.
`timescale 1ns/100ps
`default_nettype none
module dls_sequencer #(
    parameter int CH           = dls_pkg::CHANNELS,
    parameter int WDOG_LIMIT   = dls_pkg::WDOG_LIMIT_CYC,
    parameter int WDOG_REFRESH = dls_pkg::WDOG_REFRESH_CYC
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic                          clkEn,
    input  wire logic [1:0]                    startInputs,
    input  wire logic [1:0]                    startSource,
    input  wire logic                          immOffCfg,
    input  wire logic                          opValid,
    input  wire logic [7:0]                    opCode,
    input  wire logic [7:0]                    opPage,
    input  wire logic [CH-1:0]                 groupSelect,
    input  wire logic [CH-1:0]                 eventMode,
    input  wire logic [CH*4-1:0]               eventSource,
    input  wire logic [CH-1:0]                 sigWait,
    input  wire logic [CH*4-1:0]               sigMatch,
    input  wire logic [CH*4-1:0]               sigEmit,
    input  wire logic [CH-1:0]                 enablePolarity,
    input  wire logic [CH*dls_pkg::TIME_W-1:0] onDelay,
    input  wire logic [CH*dls_pkg::TIME_W-1:0] offDelay,
    input  wire logic [CH*dls_pkg::TIME_W-1:0] rampLimit,
    input  wire logic [dls_pkg::TIME_W-1:0]    eventLimit,
    input  wire logic                          logicStart,
    input  wire logic [CH-1:0]                 remoteSenseGood,
    input  wire logic [CH-1:0]                 channelFault,
    input  wire logic [CH*3-1:0]               faultToLine,
    input  wire logic [CH*3-1:0]               lineListen,
    input  wire logic [1:0]                    lineExtraEn,
    input  wire logic [2:0]                    shutdownLineIn,
    input  wire logic                          signatureLineIn,
    input  wire logic [3:0]                    signatureRx,
    input  wire logic                          signatureRxValid,
    input  wire logic                          memCheckDone,
    input  wire logic                          memCheckFail,
    input  wire logic                          wdogKick,
    input  wire logic                          alertEnable,
    input  wire logic                          statusClear,
    output logic      [CH-1:0]                 supplyEnableOutput,
    output logic      [CH-1:0]                 supplyEnableOe,
    output logic                               marginPulse7Oe,
    output logic      [2:0]                    shutdownLineOut,
    output logic      [2:0]                    shutdownLineOe,
    output logic                               signatureEmitReq,
    output logic      [3:0]                    signatureEmitCode,
    output logic      [CH-1:0]                 timeFaultFlag,
    output logic                               statusMfrFlag,
    output logic                               watchdogFlag,
    output logic                               alertOut,
    output logic                               wdogResetReq
);
    import dls_pkg::*;

    initial begin
        if (CH < 11 || CH > 16) $error("CH must be 11..16");
        if (WDOG_REFRESH >= WDOG_LIMIT) $error("refresh not below limit");
    end

    localparam int TICK_W = $clog2(TICK_CYC + 1);
    localparam int WD_W   = $clog2(WDOG_LIMIT + 1);
    localparam int SUPPLY_10 = 10;

    logic [1:0]    startSync;
    logic [2:0]    lineSync;
    logic          sigLineSync;
    logic [1:0]    startPrev_ff;
    logic          powerUp_ff;
    logic [TICK_W-1:0] tick_ff;
    logic          tick;
    logic [CH-1:0] enRaw, tFault, pgPrev_ff;
    logic [2:0]    lineAsserted;
    logic          nvBad_ff;
    logic [WD_W-1:0] wdCnt_ff;

    dls_sync #(.W(6)) uSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .din     ({startInputs, shutdownLineIn, signatureLineIn}),
        .dout    ({startSync, lineSync, sigLineSync})
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= '0;
        end else if (clkEn) begin
            tick_ff <= (tick_ff == TICK_W'(TICK_CYC - 1)) ? '0 : tick_ff + 1'b1;
        end
    end
    assign tick = (tick_ff == TICK_W'(TICK_CYC - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startPrev_ff <= '0;
            powerUp_ff   <= 1'b1;
            nvBad_ff     <= 1'b0;
        end else if (clkEn) begin
            startPrev_ff <= startSync;
            if (memCheckDone) begin
                powerUp_ff <= 1'b0;
                nvBad_ff   <= memCheckFail;
            end
        end
    end

    logic       pinEn, cmdEn, allPage;
    logic [1:0] grpOn, grpSoft, grpImm, pinRise, pinFall;
    always_comb begin
        pinEn   = (startSource == SRC_PIN) || (startSource == SRC_BOTH);
        cmdEn   = (startSource == SRC_CMD) || (startSource == SRC_BOTH);
        allPage = (opPage == PAGE_ALL);
        pinRise = startSync & ~startPrev_ff;
        pinFall = ~startSync & startPrev_ff;
        grpOn   = pinEn ? pinRise : 2'b00;
        grpSoft = (pinEn && !immOffCfg) ? pinFall : 2'b00;
        grpImm  = (pinEn && immOffCfg) ? pinFall : 2'b00;
        if (opValid && cmdEn && allPage) begin
            case (opCode)
                OP_ON_BOTH:   grpOn   = 2'b11;
                OP_ON_A:      grpOn   = grpOn | 2'b01;
                OP_ON_B:      grpOn   = grpOn | 2'b10;
                OP_SOFT_BOTH: grpSoft = 2'b11;
                OP_SOFT_A:    grpSoft = grpSoft | 2'b01;
                OP_SOFT_B:    grpSoft = grpSoft | 2'b10;
                OP_IMM_BOTH:  grpImm  = 2'b11;
                OP_IMM_A:     grpImm  = grpImm | 2'b01;
                OP_IMM_B:     grpImm  = grpImm | 2'b10;
                default:      grpOn   = grpOn;
            endcase
        end
        if (immOffCfg) begin
            grpImm  = grpImm | grpSoft;
            grpSoft = 2'b00;
        end
    end

    assign lineAsserted = lineSync & {lineExtraEn, 1'b1};

    genvar i;
    generate
        for (i = 0; i < CH; i++) begin : gCh
            logic       grp, pageHit, chOn, chSoft, chImm, evtHit, fBlk;
            logic [3:0] evSrc;
            assign grp     = groupSelect[i];
            assign pageHit = opValid && cmdEn && (opPage == 8'(i));
            assign evSrc   = eventSource[i*4 +: 4];
            assign evtHit  = sigWait[i]
                ? (signatureRxValid && signatureRx == sigMatch[i*4 +: 4])
                : remoteSenseGood[evSrc];
            assign fBlk    = channelFault[i] || nvBad_ff;
            assign chOn    = !nvBad_ff && (grpOn[grp] || powerUp_ff && memCheckDone
                           && !memCheckFail || logicStart
                           || pageHit && opCode == OP_ON_BOTH);
            assign chSoft  = grpSoft[grp] || pageHit && opCode == OP_SOFT_BOTH
                           || |(lineAsserted & lineListen[i*3 +: 3]);
            assign chImm   = grpImm[grp] || pageHit && opCode == OP_IMM_BOTH
                           || nvBad_ff;
            dls_channel uCh (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .clkEn      (clkEn),
                .tick       (tick),
                .goOn       (chOn),
                .goSoftOff  (chSoft),
                .goImmOff   (chImm),
                .eventMode  (eventMode[i] || sigWait[i]),
                .eventHit   (evtHit),
                .faultBlock (fBlk),
                .powerGood  (remoteSenseGood[i]),
                .onDelay    (onDelay[i*TIME_W +: TIME_W]),
                .offDelay   (offDelay[i*TIME_W +: TIME_W]),
                .rampLimit  (rampLimit[i*TIME_W +: TIME_W]),
                .eventLimit (eventLimit),
                .enable     (enRaw[i]),
                .timeFault  (tFault[i])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            supplyEnableOutput <= '0;
            supplyEnableOe     <= '0;
            marginPulse7Oe     <= 1'b0;
        end else if (clkEn) begin
            supplyEnableOutput <= enRaw ~^ enablePolarity;
            supplyEnableOe     <= {CH{~nvBad_ff}};
            supplyEnableOe[SUPPLY_10] <= ~nvBad_ff & ~lineExtraEn[1];
            marginPulse7Oe     <= ~nvBad_ff & ~lineExtraEn[0];
        end
    end

    // Shutdown lines are open-drain, active low: drive low, else release.
    logic [2:0] lineReq;
    always_comb begin
        lineReq = {2'b00, nvBad_ff};
        for (int k = 0; k < CH; k++) begin
            if (channelFault[k] || tFault[k]) begin
                lineReq = lineReq | faultToLine[k*3 +: 3];
            end
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shutdownLineOut <= '0;
            shutdownLineOe  <= '0;
            timeFaultFlag   <= '0;
        end else if (clkEn) begin
            shutdownLineOut <= '0;
            shutdownLineOe  <= lineReq & {lineExtraEn, 1'b1};
            // The set wins over a clear arriving in the same cycle.
            timeFaultFlag   <= (statusClear ? '0 : timeFaultFlag) | tFault;
        end
    end

    // Signature emission on a rising power-good; spacing is the system's task.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pgPrev_ff         <= '0;
            signatureEmitReq  <= 1'b0;
            signatureEmitCode <= SIG_NONE;
        end else if (clkEn) begin
            pgPrev_ff        <= remoteSenseGood & enRaw;
            signatureEmitReq <= 1'b0;
            for (int k = 0; k < CH; k++) begin
                if (enRaw[k] && remoteSenseGood[k] && !pgPrev_ff[k]
                    && sigEmit[k*4 +: 4] != SIG_NONE) begin
                    signatureEmitReq  <= 1'b1;
                    signatureEmitCode <= sigEmit[k*4 +: 4];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt_ff     <= '0;
            wdogResetReq <= 1'b0;
        end else if (clkEn) begin
            wdogResetReq <= 1'b0;
            if (wdogKick) begin
                wdCnt_ff <= '0;
            end else if (wdCnt_ff == WD_W'(WDOG_LIMIT - 1)) begin
                wdCnt_ff     <= '0;
                wdogResetReq <= 1'b1;
            end else begin
                wdCnt_ff <= wdCnt_ff + 1'b1;
            end
        end
    end

    // Flags survive the reload request; they live outside the reloaded state.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            statusMfrFlag <= 1'b0;
            watchdogFlag  <= 1'b0;
            alertOut      <= 1'b0;
        end else if (clkEn) begin
            if (wdogResetReq) begin
                statusMfrFlag <= 1'b1;
                watchdogFlag  <= 1'b1;
                alertOut      <= alertEnable;
            end else if (statusClear) begin
                statusMfrFlag <= 1'b0;
                watchdogFlag  <= 1'b0;
                alertOut      <= 1'b0;
            end
        end
    end
endmodule : dls_sequencer
`default_nettype wire

/* dls_pkg.sv */
// Package for the dual-loop supply sequencer: commands, timing, states.
// Assumes the 50 MHz system clock of the sequencer.
package dls_pkg;
    localparam int CHANNELS        = 12;
    localparam int CLK_HZ          = 50000000;
    // Delay and limit fields count 200 us ticks; 0000h disables a limit.
    localparam int TICK_US         = 200;
    localparam int TICK_CYC        = CLK_HZ / 1000000 * TICK_US;
    localparam int WDOG_REFRESH_MS = 5;
    localparam int WDOG_LIMIT_MS   = 210;
    localparam int WDOG_REFRESH_CYC = CLK_HZ / 1000 * WDOG_REFRESH_MS;
    localparam int WDOG_LIMIT_CYC  = CLK_HZ / 1000 * WDOG_LIMIT_MS;
    localparam int TIME_W          = 16;
    localparam logic [TIME_W-1:0] LIMIT_OFF = 16'h0000;
    localparam logic [7:0] PAGE_ALL     = 8'hff;
    localparam logic [7:0] OP_ON_BOTH   = 8'h80;
    localparam logic [7:0] OP_ON_A      = 8'h81;
    localparam logic [7:0] OP_ON_B      = 8'h82;
    localparam logic [7:0] OP_SOFT_BOTH = 8'h40;
    localparam logic [7:0] OP_SOFT_A    = 8'h41;
    localparam logic [7:0] OP_SOFT_B    = 8'h42;
    localparam logic [7:0] OP_IMM_BOTH  = 8'h00;
    localparam logic [7:0] OP_IMM_A     = 8'h01;
    localparam logic [7:0] OP_IMM_B     = 8'h02;
    localparam logic [1:0] SRC_PIN      = 2'h1;
    localparam logic [1:0] SRC_CMD      = 2'h2;
    localparam logic [1:0] SRC_BOTH     = 2'h3;
    localparam logic [3:0] SIG_NONE     = 4'h0;
    typedef enum logic [2:0] {
        CH_OFF, CH_WAIT_EVT, CH_DELAY_ON, CH_RAMP, CH_ON, CH_DELAY_OFF, CH_FAULT
    } dls_ch_state_t;
endpackage : dls_pkg

/* dls_channel.sv */
// One sequencing channel: on/off delays, event wait and power-up limit.
// Assumes tick is a one-cycle pulse every 200 us and inputs are synchronous.
`timescale 1ns/100ps
`default_nettype none
module dls_channel
    import dls_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              tick,
    input  wire logic              goOn,
    input  wire logic              goSoftOff,
    input  wire logic              goImmOff,
    input  wire logic              eventMode,
    input  wire logic              eventHit,
    input  wire logic              faultBlock,
    input  wire logic              powerGood,
    input  wire logic [TIME_W-1:0] onDelay,
    input  wire logic [TIME_W-1:0] offDelay,
    input  wire logic [TIME_W-1:0] rampLimit,
    input  wire logic [TIME_W-1:0] eventLimit,
    output logic                   enable,
    output logic                   timeFault
);
    dls_ch_state_t     state_ff;
    logic [TIME_W-1:0] cnt_ff, lim_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= CH_OFF;
            cnt_ff    <= '0;
            lim_ff    <= '0;
            timeFault <= 1'b0;
        end else if (clkEn) begin
            timeFault <= 1'b0;
            if (tick && cnt_ff != '0) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            if (tick && lim_ff != '0) begin
                lim_ff <= lim_ff - 1'b1;
            end
            if (goImmOff) begin
                state_ff <= CH_OFF;
            end else if (goSoftOff && state_ff != CH_OFF && state_ff != CH_DELAY_OFF) begin
                state_ff <= CH_DELAY_OFF;
                cnt_ff   <= offDelay;
            end else begin
                case (state_ff)
                    CH_OFF: begin
                        if (goOn) begin
                            state_ff <= eventMode ? CH_WAIT_EVT : CH_DELAY_ON;
                            cnt_ff   <= onDelay;
                            lim_ff   <= eventLimit;
                        end
                    end
                    CH_WAIT_EVT: begin
                        if (eventHit) begin
                            state_ff <= CH_DELAY_ON;
                            cnt_ff   <= onDelay;
                        end else if (eventLimit != LIMIT_OFF && lim_ff == '0) begin
                            state_ff  <= CH_FAULT;
                            timeFault <= 1'b1;
                        end
                    end
                    CH_DELAY_ON: begin
                        if (cnt_ff == '0 && !faultBlock) begin
                            state_ff <= CH_RAMP;
                            lim_ff   <= rampLimit;
                        end
                    end
                    CH_RAMP: begin
                        if (powerGood) begin
                            state_ff <= CH_ON;
                        end else if (rampLimit != LIMIT_OFF && lim_ff == '0) begin
                            state_ff  <= CH_FAULT;
                            timeFault <= 1'b1;
                        end
                    end
                    CH_ON: ;
                    CH_DELAY_OFF: begin
                        if (cnt_ff == '0) begin
                            state_ff <= CH_OFF;
                        end
                    end
                    CH_FAULT: ; // Latched off until an off command moves it out of CH_FAULT.
                    default: state_ff <= CH_OFF;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enable <= 1'b0;
        end else if (clkEn) begin
            enable <= (state_ff == CH_RAMP) || (state_ff == CH_ON)
                   || (state_ff == CH_DELAY_OFF && cnt_ff != '0);
        end
    end
endmodule : dls_channel
`default_nettype wire

/* dls_sync.sv */
// Two-flop synchroniser for a bus of pin inputs.
// Assumes asynchronous inputs; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module dls_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clkEn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            dout    <= '0;
        end else if (clkEn) begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : dls_sync
`default_nettype wire

/* dls_sequencer_props.sv */
// Checker for the dual-loop supply sequencer, bound to its top ports.
// Assumes one clock domain and the active-low reset of the top module.
`timescale 1ns/100ps
`default_nettype none
module dls_sequencer_props
    import dls_pkg::*;
#(
    parameter int CH         = 12,
    parameter int WDOG_LIMIT = 200
) (
    input wire logic          clk_sys, rst_n, opValid, memCheckDone, memCheckFail,
    input wire logic          wdogKick, alertEnable, marginPulse7Oe, signatureEmitReq,
    input wire logic          statusMfrFlag, watchdogFlag, alertOut, wdogResetReq,
    input wire logic [1:0]    startSource, lineExtraEn,
    input wire logic [2:0]    shutdownLineOe,
    input wire logic [3:0]    signatureEmitCode,
    input wire logic [7:0]    opCode, opPage,
    input wire logic [CH-1:0] enablePolarity, channelFault, supplyEnableOutput, supplyEnableOe
);
    logic [CH-1:0] onVec;
    logic          memBad_ff;
    int            quiet_ff;
    assign onVec = ~(supplyEnableOutput ^ enablePolarity) & supplyEnableOe;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            memBad_ff <= 1'b0;
        end else if (memCheckDone && memCheckFail) begin
            memBad_ff <= 1'b1;
        end
    end
    // A small margin absorbs the refresh pipeline; a stuck counter still fails.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            quiet_ff <= 0;
        end else begin
            quiet_ff <= (wdogKick || wdogResetReq) ? 0 : quiet_ff + 1;
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    imm_off_a: assert property (opValid && opPage == PAGE_ALL && opCode == OP_IMM_BOTH
        && startSource[1] |-> ##[1:4] onVec == '0) else $error("off late");
    fault_gate_a: assert property ((onVec & ~$past(onVec) & $past(channelFault)
        & $past(channelFault, 2) & $past(channelFault, 3)) == '0) else $error("on under fault");
    mem_fail_a: assert property (memBad_ff [*4] |-> shutdownLineOe[0]
        && supplyEnableOe == '0) else $error("bad memory on");
    wdog_bound_a: assert property (quiet_ff <= WDOG_LIMIT + 8)
        else $error("watchdog late");
    wdog_early_a: assert property (wdogResetReq |-> quiet_ff >= WDOG_LIMIT - 8)
        else $error("watchdog early");
    wdog_flags_a: assert property (wdogResetReq |-> ##[1:3] (watchdogFlag && statusMfrFlag
        && (alertOut || !alertEnable))) else $error("no watchdog flags");
    line_borrow_a: assert property ((lineExtraEn == 2'h3) [*3] |-> !supplyEnableOe[10]
        && !marginPulse7Oe) else $error("borrowed pin driven");
    sig_pulse_a: assert property (signatureEmitReq |-> signatureEmitCode != SIG_NONE
        ##1 !signatureEmitReq) else $error("bad signature");
    cover property (wdogResetReq);
    cover property (signatureEmitReq);
    cover property (memBad_ff && shutdownLineOe[0]);
endmodule : dls_sequencer_props
bind dls_sequencer dls_sequencer_props #(.CH(CH), .WDOG_LIMIT(WDOG_LIMIT)) u_props (.*);
`default_nettype wire

/* dls_supply_model.sv */
// Model of the supplies and shared lines around the sequencer.
// Assumes power-good eight cycles after an active enable; DEAD supplies never.
`timescale 1ns/100ps
`default_nettype none
module dls_supply_model #(
    parameter int            CH   = 12,
    parameter logic [CH-1:0] DEAD = '0
) (
    input  wire logic          clk_sys, signatureEmitReq,
    input  wire logic [CH-1:0] supplyEnableOutput, supplyEnableOe, enablePolarity,
    input  wire logic [2:0]    shutdownLineOe, extLine,
    output logic      [CH-1:0] remoteSenseGood,
    output logic      [2:0]    shutdownLineIn,
    output logic               signatureLineIn
);
    logic [3:0] ramp [CH] = '{default: 4'h0};
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < CH; i++) begin
            if (DEAD[i] || !supplyEnableOe[i] || supplyEnableOutput[i] != enablePolarity[i]) begin
                ramp[i] <= 4'h0;
            end else if (ramp[i] != 4'h8) begin
                ramp[i] <= ramp[i] + 4'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            remoteSenseGood[i] = (ramp[i] == 4'h8);
        end
    end
    // Lines are wired across devices; extLine stands for a fault elsewhere.
    assign shutdownLineIn = shutdownLineOe | extLine;
    assign signatureLineIn = ~signatureEmitReq;
endmodule : dls_supply_model
`default_nettype wire

/* dls_sequencer_tb_top.sv */
// Testbench for the dual-loop supply sequencer: commands, pins, faults, watchdog.
// Assumes the supply model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module dls_sequencer_tb_top;
    import dls_pkg::*;
    localparam int N = 12;
    logic            clk_sys, rst_n, opValid, logicStart, signatureRxValid, memCheckDone;
    logic            memCheckFail, wdogKick, alertEnable, statusClear, signatureLineIn, kickOn;
    logic            marginPulse7Oe, signatureEmitReq, statusMfrFlag, watchdogFlag, alertOut;
    logic            wdogResetReq, clkEn = 1'b1, immOffCfg = 1'b0;
    logic [1:0]      startInputs, lineExtraEn, startSource = SRC_BOTH;
    logic [2:0]      extLine, shutdownLineIn, shutdownLineOut, shutdownLineOe;
    logic [3:0]      signatureEmitCode, signatureRx = 4'h5;
    logic [7:0]      opCode, opPage;
    logic [15:0]     eventLimit = 16'h0000;
    logic [N-1:0]    channelFault, remoteSenseGood, supplyEnableOutput, supplyEnableOe;
    logic [N-1:0]    timeFaultFlag, onV, sigWait = '0, enablePolarity = 12'h555;
    logic [N-1:0]    groupSelect = 12'hfc0, eventMode = 12'h002;
    logic [N*4-1:0]  eventSource = '0, sigMatch = '0, sigEmit = 48'h5;
    logic [N*16-1:0] onDelay = '0, offDelay = '0, rampLimit = 192'h1 << 48;
    logic [N*3-1:0]  faultToLine = '0, lineListen = {N{3'h1}};
    int              mismatches = 0, compares = 0;
    logic [7:0]      codes [11] = '{OP_IMM_BOTH, OP_ON_B, OP_ON_A, OP_IMM_A, OP_ON_BOTH,
                         OP_SOFT_A, OP_SOFT_BOTH, OP_ON_BOTH, OP_SOFT_B, OP_IMM_B, OP_IMM_BOTH};
    logic [N-1:0]    want [11] = '{12'h000, 12'hfc0, 12'hff7, 12'hfc0, 12'hff7, 12'hfc0,
                         12'h000, 12'hff7, 12'h037, 12'h037, 12'h000};
    // Supply 3 is dead, so onV leaves it out.
    assign onV = ~(supplyEnableOutput ^ enablePolarity) & supplyEnableOe & ~12'h008;
    dls_sequencer #(.WDOG_LIMIT(200), .WDOG_REFRESH(50)) DUT (.*);
    dls_supply_model #(.CH(N), .DEAD(12'h008)) u_sup (.*);
    task automatic chk(input string nm, input logic [N-1:0] e, g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic op(input logic [7:0] c, input logic [7:0] p);
        opCode = c;
        opPage = p;
        opValid = 1'b1;
        @(negedge clk_sys) opValid = 1'b0;
        w40();
    endtask : op
    task automatic w40;
        repeat (40) @(negedge clk_sys);
    endtask : w40
    task automatic boot(input logic fail);
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        memCheckFail = fail;
        memCheckDone = 1'b1;
        @(negedge clk_sys) memCheckDone = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask : boot
    task automatic final_report;
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial forever begin
        repeat (50) @(negedge clk_sys);
        wdogKick = kickOn;
        @(negedge clk_sys) wdogKick = 1'b0;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        final_report();
    end
    initial begin
        {opValid, logicStart, signatureRxValid, memCheckDone, memCheckFail, wdogKick} = '0;
        {alertEnable, statusClear, startInputs, lineExtraEn, extLine, opCode, opPage} = '0;
        channelFault = '0;
        kickOn = 1'b1;
        boot(1'b0);
        op(OP_IMM_BOTH, PAGE_ALL);
        chk("start off", 12'h000, onV);
        op(OP_ON_A, PAGE_ALL);
        chk("group a on", 12'h037, onV);
        repeat (20100) @(negedge clk_sys);
        chk("ramp fault", 12'h008, timeFaultFlag);
        startInputs = 2'h2;
        w40();
        chk("pin b on", 12'hff7, onV);
        {logicStart, signatureRxValid} = 2'b11;
        w40();
        {logicStart, signatureRxValid} = 2'b00;
        w40();
        chk("no logic off", 12'hff7, onV);
        channelFault = 12'h080;
        startInputs = 2'h0;
        w40();
        chk("pin b off", 12'h037, onV);
        startInputs = 2'h2;
        w40();
        chk("fault gate", 12'hf77, onV);
        channelFault = 12'h000;
        for (int k = 0; k < 11; k++) begin
            op(codes[k], PAGE_ALL);
            chk("group op", want[k], onV);
        end
        op(OP_ON_BOTH, 8'h05);
        chk("page op", 12'h020, onV);
        op(OP_ON_BOTH, PAGE_ALL);
        extLine = 3'h1;
        w40();
        chk("line off", 12'h000, onV);
        extLine = 3'h0;
        lineExtraEn = 2'h3;
        repeat (8) @(negedge clk_sys);
        chk("borrowed", 12'h000, {10'h0, marginPulse7Oe, supplyEnableOe[10]});
        alertEnable = 1'b1;
        kickOn = 1'b0;
        repeat (260) @(negedge clk_sys);
        chk("wdog flags", 12'h007, {9'h0, watchdogFlag, statusMfrFlag, alertOut});
        kickOn = 1'b1;
        statusClear = 1'b1;
        @(negedge clk_sys) statusClear = 1'b0;
        boot(1'b1);
        op(OP_ON_BOTH, PAGE_ALL);
        chk("mem line", 12'h001, {11'h0, shutdownLineOe[0]});
        chk("mem oe", 12'h000, supplyEnableOe);
        final_report();
    end
endmodule : dls_sequencer_tb_top
`default_nettype wire
